// ### asq_conv_ctrl.sv
// asq_conv_ctrl: conversion start, busy, track-and-hold and host port
// Behaviour
// - mode seq=0 shadow_use_bit=1 cycles through channels set in the shadow mask
// - after shadow load, next conversion uses the lowest enabled channel
// - after each completed conversion, next one uses next higher enabled channel, then wraps
// - control write with seq,shadow_use_bit = 1,0 keeps running sequence intact
// - sequence holds until a write with any other seq,shadow_use_bit code
// - seq=1 shadow_use_bit=1 converts channel 0 up to the address, then repeats
// - consecutive mode needs no shadow; first conversion is channel 0
// - reference bit 1 selects internal, 0 selects external reference
// - data port is 12 bits; word mode pin high, byte mode pin low
// - start falling edge begins conversion; busy high throughout
// - start rising before 14th clock fall aborts, track resumes
// - busy drops low at end of every conversion
// - after power-up hold until first start rising edge gives track
// - hold on start fall, track again at 13th clock rise after it
// - auto power-down modes sleep at conversion end, wake on start rise
// - seq=0 shadow_use_bit=0 converts the single addressed channel
// - shadow register is 8 bits, loaded by one write in either mode
`timescale 1ns/10ps
`default_nettype none
module asq_conv_ctrl (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        conversionStartN,
	input  wire logic        conversionClockIn,
	input  wire logic        writeN,
	input  wire logic        chipSelectN,
	input  wire logic        wordMode,
	input  wire logic        highByteEnable,
	input  wire logic        shadowSelect,
	input  wire logic [11:0] dataIn,
	output logic             busy,
	output logic             trackMode,
	output logic             poweredDown,
	output logic             refInternal,
	output logic [2:0]       convChannel,
	output logic [1:0]       powerMode,
	output logic [11:0]      controlWord
);
	// ==========================================================
	// pin synchronisers: three stages, change counts when 2 and 3 agree
	logic [2:0] cvSync_reg;
	logic [2:0] ckSync_reg;
	logic [2:0] wrSync_reg;
	logic [2:0] cvSync_next;
	logic [2:0] ckSync_next;
	logic [2:0] wrSync_next;
	logic       cvLvl_reg;
	logic       ckLvl_reg;
	logic       wrLvl_reg;
	logic       cvLvl_next;
	logic       ckLvl_next;
	logic       wrLvl_next;

	always_comb begin
		cvSync_next = {cvSync_reg[1:0], conversionStartN};
		ckSync_next = {ckSync_reg[1:0], conversionClockIn};
		wrSync_next = {wrSync_reg[1:0], writeN | chipSelectN};
		cvLvl_next  = (cvSync_reg[1] == cvSync_reg[2]) ? cvSync_reg[2]
			: cvLvl_reg;
		ckLvl_next  = (ckSync_reg[1] == ckSync_reg[2]) ? ckSync_reg[2]
			: ckLvl_reg;
		wrLvl_next  = (wrSync_reg[1] == wrSync_reg[2]) ? wrSync_reg[2]
			: wrLvl_reg;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cvSync_reg <= 3'h7;
			ckSync_reg <= 3'h0;
			wrSync_reg <= 3'h7;
			cvLvl_reg  <= 1'b1;
			ckLvl_reg  <= 1'b0;
			wrLvl_reg  <= 1'b1;
		end else begin
			cvSync_reg <= cvSync_next;
			ckSync_reg <= ckSync_next;
			wrSync_reg <= wrSync_next;
			cvLvl_reg  <= cvLvl_next;
			ckLvl_reg  <= ckLvl_next;
			wrLvl_reg  <= wrLvl_next;
		end
	end

	logic cvFall;
	logic cvRise;
	logic ckFall;
	logic ckRise;
	logic wrRise;
	assign cvFall = cvLvl_reg & ~cvLvl_next;
	assign cvRise = ~cvLvl_reg & cvLvl_next;
	assign ckFall = ckLvl_reg & ~ckLvl_next;
	assign ckRise = ~ckLvl_reg & ckLvl_next;
	assign wrRise = ~wrLvl_reg & wrLvl_next;

	// ==========================================================
	// data capture: data held stable around write rise, sample it late
	logic [11:0] din1_reg;
	logic [11:0] din2_reg;
	logic [11:0] din3_reg;
	logic [3:0]  sel_reg;
	logic [3:0]  sel_next;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			din1_reg <= 12'h000;
			din2_reg <= 12'h000;
			din3_reg <= 12'h000;
			sel_reg  <= 4'h0;
		end else begin
			din1_reg <= dataIn;
			din2_reg <= din1_reg;
			din3_reg <= din2_reg;
			sel_reg  <= sel_next;
		end
	end

	// sel history: {shadow sel, high byte, word} sampled with data
	logic [2:0] selS1_reg;
	logic [2:0] selS2_reg;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			selS1_reg <= 3'h0;
			selS2_reg <= 3'h0;
		end else begin
			selS1_reg <= {shadowSelect, highByteEnable, wordMode};
			selS2_reg <= selS1_reg;
		end
	end
	always_comb begin
		sel_next = {1'b0, selS2_reg};
	end

	// ==========================================================
	// control word assembly
	logic [11:0] cw_reg;
	logic [11:0] cw_next;
	logic [7:0]  lowByte_reg;
	logic [7:0]  lowByte_next;
	logic        cwWrite;
	logic        shdWrite;
	logic [11:0] cwCand;

	always_comb begin
		cw_next      = cw_reg;
		lowByte_next = lowByte_reg;
		cwWrite      = 1'b0;
		shdWrite     = 1'b0;
		cwCand       = cw_reg;
		if (wrRise) begin
			if (sel_reg[2]) begin
				// one write loads all 8 shadow bits
				shdWrite = 1'b1;
			end else if (sel_reg[0]) begin
				// word mode: full 12 bits at once
				cwCand  = din3_reg;
				cwWrite = 1'b1;
			end else if (!sel_reg[1]) begin
				lowByte_next = din3_reg[7:0];
			end else begin
				cwCand  = {din3_reg[3:0], lowByte_reg};
				cwWrite = 1'b1;
			end
		end
		if (cwWrite) begin
			cw_next = cwCand;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cw_reg      <= asq_pkg::CW_RESET;
			lowByte_reg <= 8'h00;
		end else begin
			cw_reg      <= cw_next;
			lowByte_reg <= lowByte_next;
		end
	end

	// ==========================================================
	// channel sequencer
	asq_seq_if sq ();
	logic convDone;

	assign sq.cwWrite  = cwWrite;
	assign sq.mode     = {cwCand[asq_pkg::CW_SEQ_POS],
		cwCand[asq_pkg::CW_SHADOW_USE_BIT_POS]};
	assign sq.addr     = cwCand[asq_pkg::CW_ADDR_LSB +: 3];
	assign sq.shdWrite = shdWrite;
	assign sq.shadow   = din3_reg[7:0];
	assign sq.convDone = convDone;

	asq_channel_seq u_seq (
		.sysClk (clk),
		.sysRst (sys_rst),
		.sq     (sq)
	);

	// ==========================================================
	// conversion state machine
	asq_pkg::asq_conv_e st_reg;
	asq_pkg::asq_conv_e st_next;
	logic [4:0]         rise_reg;
	logic [4:0]         rise_next;
	logic [4:0]         fall_reg;
	logic [4:0]         fall_next;
	logic               busy_next;
	logic               track_next;
	logic               pd_next;
	logic [2:0]         ch_next;
	logic               autoPd;

	// auto power-down modes share their encodings' high bit difference
	assign autoPd = (cw_reg[asq_pkg::CW_PM1_POS] !=
		cw_reg[asq_pkg::CW_PM0_POS]);

	always_comb begin
		st_next    = st_reg;
		rise_next  = rise_reg;
		fall_next  = fall_reg;
		busy_next  = busy;
		track_next = trackMode;
		pd_next    = poweredDown;
		ch_next    = convChannel;
		convDone   = 1'b0;
		case (st_reg)
			asq_pkg::CS_HOLD0, asq_pkg::CS_PDOWN: begin
				// start rise gives track and wakes
				if (cvRise) begin
					st_next    = asq_pkg::CS_TRACK;
					track_next = 1'b1;
					pd_next    = 1'b0;
				end
			end
			asq_pkg::CS_TRACK: begin
				if (cvFall) begin
					st_next    = asq_pkg::CS_CONV;
					busy_next  = 1'b1;
					track_next = 1'b0;
					rise_next  = 5'h00;
					fall_next  = 5'h00;
					ch_next    = sq.chan;
				end
			end
			asq_pkg::CS_CONV: begin
				if (ckRise && rise_reg != asq_pkg::HOLD_RISE_CNT) begin
					rise_next = rise_reg + 5'h01;
				end
				if (ckFall) begin
					fall_next = fall_reg + 5'h01;
				end
				// back to track on 13th rise
				if (ckRise && rise_reg + 5'h01 == asq_pkg::HOLD_RISE_CNT) begin
					track_next = 1'b1;
				end
				if (cvRise && fall_reg < asq_pkg::DONE_FALL_CNT) begin
					st_next    = asq_pkg::CS_TRACK;
					busy_next  = 1'b0;
					track_next = 1'b1;
				end else if (ckFall &&
					fall_reg + 5'h01 == asq_pkg::DONE_FALL_CNT) begin
					// busy low at end of conversion
					busy_next = 1'b0;
					convDone  = 1'b1;
					if (autoPd) begin
						// sleep in hold until next start rise
						st_next    = asq_pkg::CS_PDOWN;
						pd_next    = 1'b1;
						track_next = 1'b0;
					end else begin
						st_next = asq_pkg::CS_TRACK;
					end
				end
			end
			default: st_next = asq_pkg::CS_HOLD0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg      <= asq_pkg::CS_HOLD0;
			rise_reg    <= 5'h00;
			fall_reg    <= 5'h00;
			busy        <= 1'b0;
			trackMode   <= 1'b0;
			poweredDown <= 1'b0;
			convChannel <= 3'h0;
		end else begin
			st_reg      <= st_next;
			rise_reg    <= rise_next;
			fall_reg    <= fall_next;
			busy        <= busy_next;
			trackMode   <= track_next;
			poweredDown <= pd_next;
			convChannel <= ch_next;
		end
	end

	// ==========================================================
	// configuration outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			refInternal <= 1'b0;
			powerMode   <= asq_pkg::PW_NORMAL;
			controlWord <= asq_pkg::CW_RESET;
		end else begin
			// reference bit: 1 internal, 0 external
			refInternal <= cw_reg[asq_pkg::CW_REF_POS];
			powerMode   <= {cw_reg[asq_pkg::CW_PM1_POS],
				cw_reg[asq_pkg::CW_PM0_POS]};
			controlWord <= cw_reg;
		end
	end
endmodule
`default_nettype wire

// ### asq_pkg.sv
// asq_pkg: shared constants and types for the adc sequencer control block
`default_nettype none
package asq_pkg;

	// ==========================================================
	// widths
	localparam int NUM_CHAN  = 8;
	localparam int DATA_W    = 12;

	// ==========================================================
	// control word layout (12-bit word)
	localparam int CW_REF_POS   = 1;
	localparam int CW_SHADOW_USE_BIT_POS  = 3;
	localparam int CW_SEQ_POS   = 4;
	localparam int CW_PM0_POS   = 6;
	localparam int CW_PM1_POS   = 7;
	// address takes the top three bits of the word
	localparam int CW_ADDR_LSB  = 9;

	// ==========================================================
	// reset values
	localparam logic [11:0] CW_RESET     = 12'h000;
	localparam logic [7:0]  SHADOW_RESET = 8'h00;

	// ==========================================================
	// conversion timing: hold and done counts in conversion clock edges, acquisition and clock period in ns
	localparam logic [4:0] HOLD_RISE_CNT = 5'h0d;
	localparam logic [4:0] DONE_FALL_CNT = 5'h0e;
	localparam int         ACQ_NS        = 125;
	localparam int         CLK_NS        = 50;
	localparam int         ACQ_CYC       = (ACQ_NS + CLK_NS - 1) / CLK_NS;

	// ==========================================================
	// sequencing modes {seq, shadow_use_bit}
	typedef enum logic [1:0] {
		SM_SINGLE = 2'b00,
		SM_PROG   = 2'b01,
		SM_KEEP   = 2'b10,
		SM_CONSEC = 2'b11
	} asq_mode_e;

	// power modes {pm1, pm0}
	typedef enum logic [1:0] {
		PW_NORMAL   = 2'b00,
		PW_AUTOSHDN = 2'b01,
		PW_AUTOSTBY = 2'b10,
		PW_FULLSHDN = 2'b11
	} asq_pwr_e;

	// conversion state
	typedef enum logic [1:0] {
		CS_HOLD0 = 2'b00,
		CS_TRACK = 2'b01,
		CS_CONV  = 2'b10,
		CS_PDOWN = 2'b11
	} asq_conv_e;

endpackage
`default_nettype wire

// ### asq_seq_if.sv
// asq_seq_if: channel sequencer carrier between control and sequencer
`timescale 1ns/10ps
`default_nettype none
interface asq_seq_if;
	logic       cwWrite;
	logic [1:0] mode;
	logic [2:0] addr;
	logic       shdWrite;
	logic [7:0] shadow;
	logic       convDone;
	logic [2:0] chan;

	modport ctrl (
		output cwWrite,
		output mode,
		output addr,
		output shdWrite,
		output shadow,
		output convDone,
		input  chan
	);
	modport seq (
		input  cwWrite,
		input  mode,
		input  addr,
		input  shdWrite,
		input  shadow,
		input  convDone,
		output chan
	);
endinterface
`default_nettype wire

// ### asq_channel_seq.sv
// asq_channel_seq: channel pointer for single, programmed and consecutive
`timescale 1ns/10ps
`default_nettype none
module asq_channel_seq (
	input  wire logic sysClk,
	input  wire logic sysRst,
	asq_seq_if.seq    sq
);
	logic [2:0] chan_reg;
	logic [2:0] chan_next;
	logic [1:0] mode_reg;
	logic [1:0] mode_next;
	logic [2:0] last_reg;
	logic [2:0] last_next;
	logic [7:0] shd_reg;
	logic [7:0] shd_next;

	// lowest set bit at or above start, wrapping; start itself if none
	function automatic logic [2:0] nextSet(input logic [7:0] m,
		input logic [2:0] start);
		logic [2:0] r;
		logic       hit;
		logic [2:0] idx;
		r = start;
		hit = 1'b0;
		for (int i = 0; i < 8; i++) begin
			idx = start + i[2:0];
			if (!hit && m[idx]) begin
				r = idx;
				hit = 1'b1;
			end
		end
		return r;
	endfunction

	always_comb begin
		chan_next = chan_reg;
		mode_next = mode_reg;
		last_next = last_reg;
		shd_next  = shd_reg;
		if (sq.shdWrite) begin
			shd_next = sq.shadow;
			chan_next = nextSet(sq.shadow, 3'h0);
		end else if (sq.cwWrite) begin
			if (sq.mode != asq_pkg::SM_KEEP) begin
				mode_next = sq.mode;
				last_next = sq.addr;
				case (sq.mode)
					asq_pkg::SM_SINGLE: chan_next = sq.addr;
					asq_pkg::SM_CONSEC: chan_next = 3'h0;
					asq_pkg::SM_PROG:   chan_next = nextSet(shd_reg, 3'h0);
					default:            chan_next = chan_reg;
				endcase
			end
		end else if (sq.convDone) begin
			case (mode_reg)
				asq_pkg::SM_PROG:
					chan_next = nextSet(shd_reg, chan_reg + 3'h1);
				asq_pkg::SM_CONSEC:
					chan_next = (chan_reg >= last_reg) ? 3'h0
						: chan_reg + 3'h1;
				default: chan_next = chan_reg;
			endcase
		end
	end

	always_ff @(posedge sysClk) begin
		if (sysRst) begin
			chan_reg <= 3'h0;
			mode_reg <= asq_pkg::SM_SINGLE;
			last_reg <= 3'h0;
			shd_reg  <= asq_pkg::SHADOW_RESET;
		end else begin
			chan_reg <= chan_next;
			mode_reg <= mode_next;
			last_reg <= last_next;
			shd_reg  <= shd_next;
		end
	end

	assign sq.chan = chan_reg;
endmodule
`default_nettype wire

// ### asq_conv_ctrl_sva.sv
// asq_conv_ctrl_sva: port-level checks for the conversion control block
`timescale 1ns/10ps
`default_nettype none
module asq_conv_ctrl_sva (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        conversionStartN,
	input wire logic        conversionClockIn,
	input wire logic        chipSelectN,
	input wire logic        busy,
	input wire logic        trackMode,
	input wire logic        poweredDown,
	input wire logic        refInternal,
	input wire logic [2:0]  convChannel,
	input wire logic [1:0]  powerMode,
	input wire logic [11:0] controlWord
);
	// ==========================================================
	// helper: cycles since the host last selected the part
	logic [3:0] sinceSel_reg;
	logic [3:0] sinceSel_next;
	always_comb begin
		sinceSel_next = sinceSel_reg;
		if (!chipSelectN)
			sinceSel_next = 4'h0;
		else if (sinceSel_reg != 4'hf)
			sinceSel_next = sinceSel_reg + 4'h1;
	end
	always_ff @(posedge clk) begin
		sinceSel_reg <= sys_rst ? 4'hf : sinceSel_next;
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_begin;
		$rose(busy);
	endsequence
	sequence s_wake;
		poweredDown && $rose(conversionStartN);
	endsequence
	a_start_begins: assert property (s_begin |-> !conversionStartN)
		else $error("busy rose without a low start pin");
	a_hold_on_start: assert property (s_begin |-> !trackMode)
		else $error("still tracking after conversion start");
	a_busy_ends: assert property ($fell(busy) |->
		!conversionClockIn || conversionStartN)
		else $error("busy dropped with no end or abort");
	a_track_cause: assert property ($rose(trackMode) |->
		conversionStartN || conversionClockIn || $past(conversionClockIn))
		else $error("track entered without start rise or clock rise");
	a_ref_select: assert property (!$changed(controlWord) |->
		refInternal == controlWord[asq_pkg::CW_REF_POS])
		else $error("reference select differs from control word");
	a_pm_field: assert property (!$changed(controlWord) |->
		powerMode == {controlWord[asq_pkg::CW_PM1_POS],
		controlWord[asq_pkg::CW_PM0_POS]})
		else $error("power mode differs from control word");
	a_pdown_end: assert property ($rose(poweredDown) |->
		!busy && !trackMode && (powerMode == 2'b01 || powerMode == 2'b10))
		else $error("power-down outside an auto mode or mid-conversion");
	a_wake_fast: assert property (s_wake |-> ##[1:6] !poweredDown)
		else $error("no wake after start rise");
	a_chan_steady: assert property (busy && $past(busy) |->
		$stable(convChannel))
		else $error("channel moved during a conversion");
	a_cw_by_write: assert property ($changed(controlWord) |->
		sinceSel_reg < 4'hc)
		else $error("control word changed without a write");
endmodule
bind asq_conv_ctrl asq_conv_ctrl_sva u_sva (
	.clk(clk),
	.sys_rst(sys_rst),
	.conversionStartN(conversionStartN),
	.conversionClockIn(conversionClockIn),
	.chipSelectN(chipSelectN),
	.busy(busy),
	.trackMode(trackMode),
	.poweredDown(poweredDown),
	.refInternal(refInternal),
	.convChannel(convChannel),
	.powerMode(powerMode),
	.controlWord(controlWord)
);
`default_nettype wire

// ### asq_host_model.sv
// asq_host_model: host driving start, conversion clock and writes
`timescale 1ns/10ps
`default_nettype none
module asq_host_model (
	input  wire logic   clk,
	input  wire logic   busy,
	input  wire logic   trackMode,
	output logic        conversionStartN,
	output logic        conversionClockIn,
	output logic        writeN,
	output logic        chipSelectN,
	output logic        wordMode,
	output logic        highByteEnable,
	output logic        shadowSelect,
	output logic [11:0] dataIn
);
	initial begin
		// start idles low so the first rise is seen after reset
		conversionStartN = 1'b0;
		conversionClockIn = 1'b0;
		writeN = 1'b1;
		chipSelectN = 1'b1;
		wordMode = 1'b1;
		highByteEnable = 1'b0;
		shadowSelect = 1'b0;
		dataIn = 12'h000;
	end
	task automatic write(input logic [11:0] d, input logic shd,
		input logic wm, input logic hbe);
		@(posedge clk);
		dataIn <= d;
		shadowSelect <= shd;
		wordMode <= wm;
		highByteEnable <= hbe;
		repeat (3) @(posedge clk);
		chipSelectN <= 1'b0;
		writeN <= 1'b0;
		repeat (4) @(posedge clk);
		chipSelectN <= 1'b1;
		writeN <= 1'b1;
		repeat (5) @(posedge clk);
		// released bus shows the inverse, not a stale copy
		dataIn <= ~d;
		shadowSelect <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	// rise to track, then acquisition time
	task automatic convert(input int nf, output logic trk,
		output logic bsy, output logic done);
		trk = 1'b0;
		bsy = 1'b0;
		done = 1'b0;
		@(posedge clk);
		conversionStartN <= 1'b1;
		repeat (asq_pkg::ACQ_CYC + 6) @(posedge clk);
		conversionStartN <= 1'b0;
		repeat (6) @(posedge clk);
		for (int i = 1; i <= nf; i++) begin
			conversionClockIn <= 1'b1;
			repeat (4) @(posedge clk);
			if (i == 13) begin
				#1;
				trk = trackMode;
				bsy = busy;
			end
			@(posedge clk);
			conversionClockIn <= 1'b0;
			repeat (5) @(posedge clk);
		end
		// early rise aborts; full runs rise on next call
		if (nf < 14)
			conversionStartN <= 1'b1;
		for (int w = 0; w < 12 && !done; w++) begin
			@(posedge clk);
			#1;
			done = (busy === 1'b0);
		end
	endtask
endmodule
`default_nettype wire

// ### asq_conv_ctrl_tb.sv
// asq_conv_ctrl_tb: self-checking bench for the conversion control block
`timescale 1ns/10ps
`default_nettype none
module asq_conv_ctrl_tb;
	typedef struct packed {
		logic [11:0]     cw;
		logic [7:0]      mask;
		logic            useMask;
		logic            refExp;
		logic [3:0][2:0] ch;
	} asq_row_s;
	logic        clk;
	logic        sys_rst;
	logic        conversionStartN;
	logic        conversionClockIn;
	logic        writeN;
	logic        chipSelectN;
	logic        wordMode;
	logic        highByteEnable;
	logic        shadowSelect;
	logic [11:0] dataIn;
	logic        busy;
	logic        trackMode;
	logic        poweredDown;
	logic        refInternal;
	logic [2:0]  convChannel;
	logic [1:0]  powerMode;
	logic [11:0] controlWord;
	logic        trk13;
	logic        bsy13;
	logic        done;
	int          n_errors;
	int          n_checks;
	asq_row_s    rows [4];

	asq_conv_ctrl uut (.clk(clk), .sys_rst(sys_rst),
		.conversionStartN(conversionStartN),
		.conversionClockIn(conversionClockIn), .writeN(writeN),
		.chipSelectN(chipSelectN), .wordMode(wordMode),
		.highByteEnable(highByteEnable), .shadowSelect(shadowSelect),
		.dataIn(dataIn), .busy(busy), .trackMode(trackMode),
		.poweredDown(poweredDown), .refInternal(refInternal),
		.convChannel(convChannel), .powerMode(powerMode),
		.controlWord(controlWord));
	asq_host_model host (.clk(clk), .busy(busy), .trackMode(trackMode),
		.conversionStartN(conversionStartN),
		.conversionClockIn(conversionClockIn), .writeN(writeN),
		.chipSelectN(chipSelectN), .wordMode(wordMode),
		.highByteEnable(highByteEnable), .shadowSelect(shadowSelect),
		.dataIn(dataIn));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ==========================================================
	// checking and closing
	task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d errors=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one conversion; a missing busy drop ends the run
	task automatic conv(input int nf, input logic [2:0] ch);
		host.convert(nf, trk13, bsy13, done);
		cmp(12'(convChannel), 12'(ch));
		cmp(12'(done), 12'h001);
		if (done !== 1'b1)
			final_report();
		else if (nf >= 14)
			cmp(12'({trk13, bsy13}), 12'h003);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		n_errors = 0;
		n_checks = 0;
		sys_rst = 1'b1;
		rows[0] = '{12'h402, 8'h00, 1'b0, 1'b1, {3'h2, 3'h2, 3'h2, 3'h2}};
		rows[1] = '{12'h008, 8'h2c, 1'b1, 1'b0, {3'h2, 3'h5, 3'h3, 3'h2}};
		rows[2] = '{12'h418, 8'h00, 1'b0, 1'b0, {3'h0, 3'h2, 3'h1, 3'h0}};
		rows[3] = '{12'h018, 8'h00, 1'b0, 1'b0, {3'h0, 3'h0, 3'h0, 3'h0}};
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		cmp({9'h000, busy, trackMode, poweredDown}, 12'h000);
		cmp(controlWord, 12'h000);
		foreach (rows[r]) begin
			host.write(rows[r].cw, 1'b0, 1'b1, 1'b0);
			if (rows[r].useMask)
				host.write({4'h0, rows[r].mask}, 1'b1, 1'b1, 1'b0);
			cmp(controlWord, rows[r].cw);
			cmp(12'(refInternal), 12'(rows[r].refExp));
			for (int k = 0; k < 4; k++)
				conv(14, rows[r].ch[k]);
		end
		// abort mid-conversion, keep-write, then leave the sequence
		host.write(12'h008, 1'b0, 1'b1, 1'b0);
		host.write(12'h006, 1'b1, 1'b1, 1'b0);
		conv(14, 3'h1);
		conv(10, 3'h2);
		cmp(12'(trackMode), 12'h001);
		conv(14, 3'h2);
		// keep code still loads the word, only the sequence is spared
		host.write(12'h010, 1'b0, 1'b1, 1'b0);
		cmp(controlWord, 12'h010);
		conv(14, 3'h1);
		host.write(12'h600, 1'b0, 1'b1, 1'b0);
		conv(14, 3'h3);
		// byte-mode writes, auto power-down and wake
		host.write(12'h048, 1'b0, 1'b0, 1'b0);
		host.write(12'h000, 1'b0, 1'b0, 1'b1);
		host.write(12'h080, 1'b1, 1'b0, 1'b0);
		cmp(controlWord, 12'h048);
		cmp(12'(powerMode), 12'h001);
		conv(14, 3'h7);
		cmp({10'h000, poweredDown, trackMode}, 12'h002);
		conv(14, 3'h7);
		// standby flavour of auto power-down
		host.write(12'h088, 1'b0, 1'b1, 1'b0);
		cmp(12'(powerMode), 12'h002);
		conv(14, 3'h7);
		cmp({10'h000, poweredDown, trackMode}, 12'h002);
		final_report();
	end
endmodule
`default_nettype wire
